//--- core/lvt_transmitter.sv
// flat panel serial transmitter: pixel capture, channel split, serializer,
// per pair power states and a wishbone register file
// assumes dot clock from the display pll arrives as an asynchronous pin and
// pixel data stays stable for at least five core clocks after its rise
//
// Function
// [RULE_01] single channel sends 18 colour plus 3 timing bits on three pairs
// [RULE_02] dual channel sends 36 colour plus timing bits on six pairs
// [RULE_03] channels A and B, each three data pairs and one clock pair
// [RULE_04] clock pairs emit 1100011 once per transmit clock cycle
// [RULE_05] each data pair carries seven serial bits per transmit clock period
// [RULE_06] transmit clock from 25 to 112 MHz per channel
// [RULE_07] both channels run at the same frequency, sharing pixel data
// [RULE_08] serial rate is a fixed multiple of dot clock per mode; here slots run at one per core clock, asynchronous to the dot clock
// [RULE_09] display stream taken from the pipe at dot clock rate
// [RULE_10] six bits per colour, 18 bpp, in both modes
// [RULE_11] data pairs carry colour and timing, clock pairs only clock
// [RULE_12] port enable off holds every pair in low power
// [RULE_13] unneeded pairs powered down or forced to zeros as configured
// [RULE_14] power sequencer may override pair power state during sequencing
// [RULE_15] panel timing values lockable against later writes
// [RULE_16] timing outputs stay stable across display mode changes; here switching dual mode clears or restores timing bits 0 and 16
// [RULE_17] display enable slot may carry active low blank instead
// [RULE_18] dual mode: even pixels on A, first valid pixel on A, even timings
// [RULE_19] each pair supports five drive states
// [RULE_20] load rate is dot rate or half of it, synchronous to shifting
// [RULE_21] fixed mapping of 21 bits onto three seven-slot pairs per channel
//
// The register addresses and the Wishbone register port are this design's own decisions.
`include "lvt_params.svh"
`timescale 1ns/1ps
`default_nettype none
module lvt_transmitter #(
   parameter int ADDR_W = 8
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic dot_clk_pin,
   input wire lvt_pkg::lvt_pixel_t pix_in,
   input wire logic seq_busy,
   input wire logic seq_pairs_on,
   output logic [7:0] lvds_bit,
   output logic [7:0] lvds_oe,
   output lvt_pkg::lvt_pair_vec_t lvds_state,
   output logic [31:0] panel_timing
);
   lvt_pkg::lvt_state_t st_r;
   lvt_pkg::lvt_state_t st_nxt;
   logic dot_level;
   logic dot_rise;

   lvt_edge_sync u_dot_sync (
      .clk(core_clk),
      .reset_n(reset_n),
      .pin(dot_clk_pin),
      .level(dot_level),
      .rise(dot_rise)
   );

   // byte lane merge for wishbone writes
   function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // 21 parallel bits of one channel; bit pair*7+slot is sent in that slot
   function automatic logic [20:0] chan_word(input lvt_pkg::lvt_pixel_t px,
                                             input logic blank_sel);
      logic ctl;
      ctl = blank_sel ? px.blank_n : px.pixel_valid_timing_bit; // RULE_17
      return {ctl, px.vsync, px.hsync, px.blue[5:2],
              px.blue[1:0], px.green[5:1],
              px.green[0], px.red}; // RULE_21 RULE_10 RULE_01
   endfunction

   // serial bit of pair p (0..3 within a channel) in a given slot
   function automatic logic slot_bit(input logic [20:0] word, input int p,
                                     input logic [2:0] slot, input logic zero_col);
      logic [20:0] w;
      logic [6:0] pat;
      w = zero_col ? (word & ~`LVT_COLOUR_MASK) : word;
      pat = `LVT_CLK_PAT;
      if (p == `LVT_CLK_PAIR) begin
         return pat[`LVT_LAST_SLOT - slot]; // RULE_04 RULE_11
      end
      return w[p*`LVT_SLOTS + int'(slot)]; // RULE_05
   endfunction

   function automatic logic [31:0] ctrl_word(input lvt_pkg::lvt_state_t s);
      logic [31:0] c;
      c = '0;
      c[`LVT_CTRL_EN] = s.port_en;
      c[`LVT_CTRL_DUAL] = s.dual;
      c[`LVT_CTRL_DISZ] = s.dis_zero;
      c[`LVT_CTRL_PDNZ] = s.pdn_zero;
      c[`LVT_CTRL_BLANK] = s.blank_sel;
      c[`LVT_CTRL_OVR] = s.ovr_en;
      c[`LVT_CTRL_LOCK] = s.lock;
      return c;
   endfunction

   always_comb begin
      logic req;
      logic [31:0] wv;
      logic [31:0] rv;
      logic load;
      logic [20:0] word_now;
      logic [20:0] load_a;
      logic [20:0] load_b;
      logic first;
      logic needed;
      lvt_pkg::lvt_pair_e low_pwr;
      lvt_pkg::lvt_pair_e dis_state;
      lvt_pkg::lvt_pair_e ps;
      logic [20:0] w;
      req = 1'b0;
      wv = '0;
      rv = '0;
      load = 1'b0;
      word_now = '0;
      load_a = '0;
      load_b = '0;
      first = 1'b0;
      needed = 1'b0;
      low_pwr = lvt_pkg::lvt_pdn_tri;
      dis_state = lvt_pkg::lvt_pdn_tri;
      ps = lvt_pkg::lvt_pdn_tri;
      w = '0;
      st_nxt = st_r;

      // wishbone slave: ack one cycle after the request, then low a cycle
      req = wb_cyc_i & wb_stb_i & ~st_r.ack;
      st_nxt.ack = req;
      if (req && wb_we_i) begin
         if (wb_adr_i == `LVT_ADR_CTRL) begin
            wv = merge_sel(ctrl_word(st_r), wb_dat_i, wb_sel_i);
            st_nxt.port_en = wv[`LVT_CTRL_EN];
            st_nxt.dual = wv[`LVT_CTRL_DUAL];
            st_nxt.dis_zero = wv[`LVT_CTRL_DISZ];
            st_nxt.pdn_zero = wv[`LVT_CTRL_PDNZ];
            st_nxt.blank_sel = wv[`LVT_CTRL_BLANK];
            st_nxt.ovr_en = wv[`LVT_CTRL_OVR];
            st_nxt.lock = st_r.lock | wv[`LVT_CTRL_LOCK]; // RULE_15
         end else if (wb_adr_i == `LVT_ADR_PAIR) begin
            wv = merge_sel({8'h00, st_r.pair_cfg}, wb_dat_i, wb_sel_i);
            st_nxt.pair_cfg = wv[23:0];
         end else if (wb_adr_i == `LVT_ADR_TIMING) begin
            if (!st_r.lock) begin
               st_nxt.timing = merge_sel(st_r.timing, wb_dat_i, wb_sel_i); // RULE_15
            end
         end
      end
      if (req && !wb_we_i) begin
         if (wb_adr_i == `LVT_ADR_CTRL) begin
            rv = ctrl_word(st_r);
         end else if (wb_adr_i == `LVT_ADR_PAIR) begin
            rv = {8'h00, st_r.pair_cfg};
         end else if (wb_adr_i == `LVT_ADR_TIMING) begin
            rv = st_r.timing;
         end else if (wb_adr_i == `LVT_ADR_STATUS) begin
            rv = {st_r.frames, 12'h000, st_r.busy, st_r.phase, dot_level, st_r.lock};
         end else begin
            rv = '0;
         end
         st_nxt.dat_o = rv;
      end

      // timing output copies the timing register; dual forces even values
      st_nxt.timing_out = st_r.dual ? {st_r.timing[31:17], 1'b0,
                                       st_r.timing[15:1], 1'b0}
                                    : st_r.timing; // RULE_16 RULE_18

      // pixel capture at each dot clock rise
      if (dot_rise) begin // RULE_09
         word_now = chan_word(pix_in, st_r.blank_sel);
         first = pix_in.pixel_valid_timing_bit & ~st_r.prev_valid;
         st_nxt.prev_valid = pix_in.pixel_valid_timing_bit;
         if (!st_r.dual) begin
            load = 1'b1; // RULE_20 RULE_01
            load_a = word_now;
            st_nxt.phase = 1'b0;
         end else if (first || !st_r.phase) begin
            st_nxt.hold_a = word_now; // RULE_18
            st_nxt.phase = 1'b1;
         end else begin
            load = 1'b1; // RULE_20 RULE_02 RULE_07
            load_a = st_r.hold_a;
            load_b = word_now;
            st_nxt.phase = 1'b0;
         end
      end

      // serializer: one slot per core clock, a frame starts at slot 0
      if (st_r.busy) begin
         st_nxt.slot = st_r.slot + 3'h1;
         if (st_r.slot == `LVT_LAST_SLOT) begin
            st_nxt.busy = 1'b0;
         end
      end
      if (load) begin
         st_nxt.sh_a = load_a; // RULE_08 RULE_06
         st_nxt.sh_b = load_b;
         st_nxt.slot = '0;
         st_nxt.busy = 1'b1;
         st_nxt.frames = st_r.frames + 16'h0001;
      end

      // per pair drive state and serial bit
      low_pwr = st_r.pdn_zero ? lvt_pkg::lvt_pdn_zero : lvt_pkg::lvt_pdn_tri;
      dis_state = st_r.dis_zero ? lvt_pkg::lvt_pdn_zero : lvt_pkg::lvt_pdn_tri;
      for (int i = 0; i < `LVT_PAIRS; i++) begin
         needed = (i <= `LVT_CLK_PAIR) | st_r.dual; // RULE_03
         if (!st_r.port_en) begin
            ps = low_pwr; // RULE_12
         end else if (st_r.ovr_en && seq_busy) begin
            ps = seq_pairs_on ? (needed ? lvt_pkg::lvt_active : dis_state)
                              : low_pwr; // RULE_14
         end else if (!needed) begin
            ps = dis_state; // RULE_13
         end else if (st_r.pair_cfg[i*`LVT_PAIR_W +: `LVT_PAIR_W] >
                      3'(lvt_pkg::lvt_active)) begin
            ps = lvt_pkg::lvt_active;
         end else begin
            ps = lvt_pkg::lvt_pair_e'(st_r.pair_cfg[i*`LVT_PAIR_W +: `LVT_PAIR_W]); // RULE_19
         end
         st_nxt.pstate[i] = ps;
         st_nxt.oe[i] = (ps != lvt_pkg::lvt_pdn_tri);
         w = (i <= `LVT_CLK_PAIR) ? st_r.sh_a : st_r.sh_b;
         if (st_r.busy && (ps == lvt_pkg::lvt_active || ps == lvt_pkg::lvt_send0)) begin
            st_nxt.bits[i] = slot_bit(w, i % 4, st_r.slot,
                                      ps == lvt_pkg::lvt_send0); // RULE_19 RULE_11
         end else begin
            st_nxt.bits[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
         st_r.pair_cfg <= `LVT_PAIR_RST;
         st_r.timing <= `LVT_TIMING_RST;
         st_r.timing_out <= `LVT_TIMING_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign wb_dat_o = st_r.dat_o;
   assign wb_ack_o = st_r.ack;
   assign lvds_bit = st_r.bits;
   assign lvds_oe = st_r.oe;
   assign lvds_state = st_r.pstate;
   assign panel_timing = st_r.timing_out;
endmodule
`default_nettype wire

//--- core/lvt_params.svh
// constants of the flat panel serial transmitter: offsets, fields, resets
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef LVT_PARAMS_SVH
`define LVT_PARAMS_SVH

`define LVT_ADR_CTRL 8'h00
`define LVT_ADR_PAIR 8'h04
`define LVT_ADR_TIMING 8'h08
`define LVT_ADR_STATUS 8'h0c

`define LVT_CTRL_EN 0
`define LVT_CTRL_DUAL 1
`define LVT_CTRL_DISZ 2
`define LVT_CTRL_PDNZ 3
`define LVT_CTRL_BLANK 4
`define LVT_CTRL_OVR 5
`define LVT_CTRL_LOCK 6

`define LVT_PAIR_RST 24'h924924
`define LVT_TIMING_RST 32'h0000_0000
`define LVT_PAIRS 8
`define LVT_PAIR_W 3
`define LVT_CLK_PAIR 3
`define LVT_SLOTS 7
`define LVT_LAST_SLOT 3'h6
`define LVT_CLK_PAT 7'h63
`define LVT_COLOUR_MASK 21'h03ffff
`define LVT_COLOUR_BITS 18

`endif

//--- core/lvt_pkg.sv
// types of the flat panel serial transmitter
// assumes lvt_params.svh for all numeric constants
package lvt_pkg;

   // per pair drive states, lowest power first
   typedef enum logic [2:0] {
      lvt_pdn_tri,
      lvt_pdn_zero,
      lvt_common,
      lvt_send0,
      lvt_active
   } lvt_pair_e;

   typedef lvt_pair_e [7:0] lvt_pair_vec_t;

   // one pixel from the display pipe, 6 bits per colour
   typedef struct packed {
      logic [5:0] red;
      logic [5:0] green;
      logic [5:0] blue;
      logic hsync;
      logic vsync;
      logic pixel_valid_timing_bit;
      logic blank_n;
   } lvt_pixel_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic rise;
   } lvt_sync_t;

   typedef struct packed {
      logic port_en;
      logic dual;
      logic dis_zero;
      logic pdn_zero;
      logic blank_sel;
      logic ovr_en;
      logic lock;
      logic [23:0] pair_cfg;
      logic [31:0] timing;
      logic [31:0] timing_out;
      logic ack;
      logic [31:0] dat_o;
      logic phase;
      logic prev_valid;
      logic [20:0] hold_a;
      logic [20:0] sh_a;
      logic [20:0] sh_b;
      logic [2:0] slot;
      logic busy;
      logic [7:0] bits;
      logic [7:0] oe;
      lvt_pair_vec_t pstate;
      logic [15:0] frames;
   } lvt_state_t;

endpackage

//--- core/lvt_edge_sync.sv
// three stage synchroniser with agreement filter and rising edge pulse
// assumes pin is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module lvt_edge_sync (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic pin,
   output logic level,
   output logic rise
);
   lvt_pkg::lvt_sync_t st_r;
   lvt_pkg::lvt_sync_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = pin;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // change counts once stages two and three agree
      if (st_r.s2 == st_r.s3) begin
         st_nxt.level = st_r.s3;
      end
      st_nxt.rise = st_nxt.level & ~st_r.level;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level = st_r.level;
   assign rise = st_r.rise;
endmodule
`default_nettype wire

//--- bench/lvt_chk.sv
// port checker of the flat panel serial transmitter
// assumes binding onto lvt_transmitter, one clock domain
`timescale 1ns/1ps
`default_nettype none
module lvt_chk (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic wb_ack_o,
   input wire logic [7:0] lvds_bit,
   input wire logic [7:0] lvds_oe,
   input wire lvt_pkg::lvt_pair_vec_t lvds_state,
   input wire logic [31:0] panel_timing
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   logic [7:0] quiet_r;
   logic [7:0] quiet;
   logic [7:0] oe_exp;
   logic wr_r;
   logic [2:0] pat_cnt_r;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         oe_exp[i] = lvds_state[i] != lvt_pkg::lvt_pdn_tri;
         quiet[i] = lvds_state[i] < lvt_pkg::lvt_common;
      end
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         quiet_r <= 8'h00;
         wr_r <= 1'h0;
         pat_cnt_r <= 3'h0;
      end else begin
         quiet_r <= quiet;
         wr_r <= wb_cyc_i && wb_stb_i && wb_we_i;
         // slot counter of the clock pair, so the mid-frame rise is not a start
         if (pat_cnt_r != 3'h0) begin
            pat_cnt_r <= (pat_cnt_r == 3'h6) ? 3'h0 : pat_cnt_r + 3'h1;
         end else if (lvds_bit[3]) begin
            pat_cnt_r <= 3'h1;
         end
      end
   end
   sequence frame_start_s;
      lvds_bit[3] && pat_cnt_r == 3'h0;
   endsequence
   sequence clk_pat_s;
      lvds_bit[3] [*2] ##1 !lvds_bit[3] [*3] ##1 lvds_bit[3] [*2];
   endsequence
   chk_clk_pattern: assert property (frame_start_s |-> clk_pat_s)
      else $error("clock pair pattern wrong");
   chk_frame_len: assert property (frame_start_s |-> ##7 lvds_bit == 8'h00)
      else $error("frame not seven slots");
   chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus answer late");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_oe_state: assert property ($stable(lvds_state) |-> lvds_oe == oe_exp)
      else $error("output enable disagrees with state");
   chk_quiet_pairs: assert property ((quiet_r & quiet & lvds_bit) == 8'h00)
      else $error("powered down pair toggles");
   chk_lane_lockstep: assert property (lvds_state[3] == lvt_pkg::lvt_active
      && lvds_state[7] == lvt_pkg::lvt_active && $stable(lvds_state)
      |-> lvds_bit[3] == lvds_bit[7])
      else $error("channel clocks differ");
   chk_timing_hold: assert property (!wr_r && !(wb_cyc_i && wb_stb_i && wb_we_i)
      |=> $stable(panel_timing))
      else $error("timing output moved without write");
endmodule
bind lvt_transmitter lvt_chk i_chk (.core_clk, .reset_n, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_ack_o, .lvds_bit, .lvds_oe, .lvds_state, .panel_timing);
`default_nettype wire

//--- bench/lvt_panel_rx.sv
// panel receiver model: rebuilds the 21 bit words of both channels
// assumes a frame starts on a high clock pair bit while idle
`timescale 1ns/1ps
`default_nettype none
module lvt_panel_rx (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] lvds_bit,
   output logic done,
   output logic [20:0] word_a,
   output logic [20:0] word_b,
   output logic [6:0] clk_a,
   output logic [6:0] clk_b
);
   int slot;
   int s;
   always @(posedge clk or negedge reset_n) begin
      done <= 1'h0;
      if (!reset_n) begin
         slot <= 7;
      end else begin
         s = (lvds_bit[3] && slot >= 7) ? 0 : slot;
         if (s < 7) begin
            for (int p = 0; p < 3; p++) begin
               word_a[p*7+s] <= lvds_bit[p];
               word_b[p*7+s] <= lvds_bit[p+4];
            end
            clk_a[s] <= lvds_bit[3];
            clk_b[s] <= lvds_bit[7];
            done <= s == 6;
         end
         slot <= s < 7 ? s + 1 : 7;
      end
   end
endmodule
`default_nettype wire

//--- bench/tb_lvt_transmitter.sv
// self checking bench of the flat panel serial transmitter
// assumes the receiver model and the bound port checker
`include "lvt_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_lvt_transmitter;
   logic core_clk = 1'h0, reset_n = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, v, panel_timing;
   logic wb_ack_o, dot_clk_pin = 1'h0, seq_busy = 1'h0, seq_pairs_on = 1'h0, done, dm;
   lvt_pkg::lvt_pixel_t pix_in = 22'h0;
   logic [7:0] lvds_bit, lvds_oe;
   lvt_pkg::lvt_pair_vec_t lvds_state;
   logic [20:0] word_a, word_b, qa[$], qb[$];
   logic [6:0] clk_a, clk_b;
   int err_count = 0, compares = 0, seed = 8;
   lvt_transmitter i_dut (.core_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dot_clk_pin, .pix_in, .seq_busy,
      .seq_pairs_on, .lvds_bit, .lvds_oe, .lvds_state, .panel_timing);
   lvt_panel_rx i_rx (.clk(core_clk), .reset_n, .lvds_bit, .done, .word_a, .word_b,
      .clk_a, .clk_b);
   always #12.5 core_clk = ~core_clk;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 20);
      rd = wb_dat_o;
      if (n >= 20) begin
         err_count++;
         tally_and_finish;
      end
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask
   function automatic logic [20:0] pw(input lvt_pkg::lvt_pixel_t x, input logic bs,
      input logic z);
      pw = {bs ? x.blank_n : x.pixel_valid_timing_bit, x.vsync, x.hsync, x.blue, x.green,
         x.red};
      if (z) pw[17:0] = 18'h0;
   endfunction
   task automatic send(input lvt_pkg::lvt_pixel_t x);
      @(posedge core_clk);
      pix_in <= x;
      dot_clk_pin <= 1'h1;
      repeat (4) @(posedge core_clk);
      dot_clk_pin <= 1'h0;
      repeat (3) @(posedge core_clk);
   endtask
   task automatic burst(input int n, input logic d, input logic bs, input logic z);
      lvt_pkg::lvt_pixel_t a, x;
      logic [20:0] ea[$], eb[$];
      dm = d;
      qa.delete();
      qb.delete();
      for (int i = 0; i < n; i++) begin
         x = 22'($random(seed));
         if (d) x.pixel_valid_timing_bit = i > 0;
         if (!d) begin
            ea.push_back(pw(x, bs, z));
            eb.push_back(21'h0);
         end else if (i[0]) a = x;
         else if (i > 0) begin
            ea.push_back(pw(a, bs, z));
            eb.push_back(pw(x, bs, z));
         end
         send(x);
      end
      repeat (20) @(posedge core_clk);
      check(qa.size(), ea.size());
      foreach (ea[i]) begin
         check(qa[i], ea[i]);
         check(qb[i], eb[i]);
      end
      $display("burst of %0d pixels done", n);
   endtask
   always @(posedge core_clk) begin
      if (done === 1'h1) begin
         qa.push_back(word_a);
         qb.push_back(word_b);
         check(clk_a, 7'h63);
         check(clk_b, dm ? 7'h63 : 7'h0);
      end
   end
   initial begin
      #500000;
      err_count++;
      tally_and_finish;
   end
   initial begin
      repeat (4) @(posedge core_clk);
      reset_n <= 1'h1;
      wb(0, `LVT_ADR_PAIR, 0);
      check(rd, `LVT_PAIR_RST);
      wb(0, 8'h10, 0);
      check(rd, 32'h0);
      check(lvds_oe, 8'h00);
      wb(1, `LVT_ADR_CTRL, 32'h8);
      repeat (2) @(posedge core_clk);
      check(lvds_state, {8{lvt_pkg::lvt_pdn_zero}});
      wb(1, `LVT_ADR_CTRL, 32'h5);
      repeat (2) @(posedge core_clk);
      check(lvds_state, {{4{lvt_pkg::lvt_pdn_zero}}, {4{lvt_pkg::lvt_active}}});
      burst(6, 0, 0, 0);
      wb(1, `LVT_ADR_CTRL, 32'h15);
      burst(4, 0, 1, 0);
      wb(1, `LVT_ADR_PAIR, 32'h9248db);
      burst(3, 0, 1, 1);
      wb(1, `LVT_ADR_PAIR, `LVT_PAIR_RST);
      wb(1, `LVT_ADR_CTRL, 32'h3);
      burst(7, 1, 0, 0);
      v = $random(seed);
      wb(1, `LVT_ADR_TIMING, v);
      wb(0, `LVT_ADR_TIMING, 0);
      check(rd, v);
      check(panel_timing, v & 32'hfffe_fffe);
      wb(1, `LVT_ADR_CTRL, 32'h43);
      wb(1, `LVT_ADR_TIMING, ~v);
      wb(0, `LVT_ADR_TIMING, 0);
      check(rd, v);
      wb(1, `LVT_ADR_CTRL, 32'h41);
      repeat (2) @(posedge core_clk);
      check(panel_timing, v);
      wb(1, `LVT_ADR_CTRL, 32'h21);
      seq_busy <= 1'h1;
      repeat (3) @(posedge core_clk);
      check(lvds_state, 32'h0);
      seq_pairs_on <= 1'h1;
      repeat (3) @(posedge core_clk);
      check(lvds_state, {{4{lvt_pkg::lvt_pdn_tri}}, {4{lvt_pkg::lvt_active}}});
      seq_busy <= 1'h0;
      $display("register and power tests done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
